// File: rtl/fcs_pkg.sv
// Package: command codes, pin bundle, timing counts for the flash command host
package fcs_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_EVERIFY = 8'hA0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [16:0] SIG_MAKER_ADDR = 17'h00000;
  localparam logic [16:0] SIG_DEVICE_ADDR = 17'h00001;
  localparam int CLK_PERIOD_NS = 100;
  // Write pulse low time and strobe high time, ns
  localparam int WRITE_PULSE_NS = 40;
  localparam int WRITE_HIGH_NS = 20;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read access, ns (slowest grade)
  localparam int READ_ACCESS_NS = 200;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // Write strobe high to output enable low, us
  localparam int WRITE_TO_READ_US = 6;
  localparam int WRITE_TO_READ_CYC = (WRITE_TO_READ_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Erase duration, ms
  localparam int ERASE_MS = 10;
  localparam int ERASE_CYC = ERASE_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [1:0] OP_ERASE = 2'h0;
  localparam logic [1:0] OP_SIG = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ABORT = 2'h3;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } fcs_pins_t;
endpackage : fcs_pkg

// File: rtl/fcs_host.sv
// Host sequencer that drives the flash command register over its parallel pins
`timescale 1ns/1ps
// How it works
// - Command write drops write strobe with chip select low; address and data are set up together before the fall.
// - Identification ends by the host writing another valid command.
// - Host must program all bytes to 00h before erase; caller guarantees this.
// - Host writes 20h twice: first arms erase, second launches it.
// - Erase-verify write carries A0h plus the byte address in one cycle.
// - Host repeats verify write and one read for every byte address.
// - On a failed verify, host erases again and resumes at that address; the MAX_ERASE_TRIES-th failed verify ends the operation with FAIL instead.
// - Abort writes FFh twice, then a read command.
module fcs_host #(
  parameter int ERASE_CYCLES = fcs_pkg::ERASE_CYC,
  parameter int MAX_ERASE_TRIES = 1000,
  parameter logic [16:0] LAST_ADDR = 17'h1FFFF
) (
  input wire logic SYS_CLK, // 10 MHz clock
  input wire logic RSTN, // Async reset, active low
  input wire logic START, // Pulse: begin operation in OP
  input wire logic [1:0] OP, // Operation select
  input wire logic [16:0] ADDR, // Array address for OP_READ
  output logic BUSY, // High while an operation runs
  output logic DONE, // One-cycle pulse at operation end
  output logic FAIL, // Erase gave up, valid with DONE
  output logic [7:0] RDATA, // Last byte read
  output logic [7:0] SIG_MAKER, // Maker code
  output logic [7:0] SIG_DEVICE, // Device type code
  output logic [16:0] F_ADDR, // Flash address pins
  output logic F_CE_N, // Flash chip enable
  output logic F_WE_N, // Flash write strobe
  output logic F_OE_N, // Flash output enable
  output logic [7:0] F_DQ_O, // Flash data out
  output logic F_DQ_OE, // High while host drives data
  input wire logic [7:0] F_DQ_I // Flash data in
);
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_WLOW = 9'h002, S_WHIGH = 9'h004, S_RWAIT = 9'h008, S_RDO = 9'h010,
    S_ERWAIT = 9'h020, S_NEXT = 9'h040, S_DONE = 9'h080, S_GAP = 9'h100
  } fcs_state_t;

  fcs_state_t state, next_state;
  fcs_pkg::fcs_pins_t pins, next_pins;
  logic [7:0] dq_s1, dq_s2;
  logic [3:0] step, next_step;
  logic [1:0] op, next_op;
  logic [16:0] vaddr, next_vaddr;
  logic [31:0] cnt, next_cnt;
  logic [15:0] tries, next_tries;
  logic [7:0] rdata, next_rdata, maker, next_maker, dev, next_dev;
  logic fail, next_fail;

  // Two flops on the data pins before anything reads them
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= F_DQ_I;
      dq_s2 <= dq_s1;
    end
  end

  // Per step: write command byte, or read; step list walks the whole operation
  function automatic logic [8:0] step_cmd(input logic [1:0] o, input logic [3:0] s);
    // {is_write, data}
    logic [8:0] r;
    r = {1'b0, 8'h00};
    case (o)
      fcs_pkg::OP_READ: r = (s == 4'h0) ? {1'b1, fcs_pkg::CMD_READ} : {1'b0, 8'h00};
      fcs_pkg::OP_SIG: case (s)
        4'h0: r = {1'b1, fcs_pkg::CMD_SIG};
        4'h3: r = {1'b1, fcs_pkg::CMD_READ};
        default: r = {1'b0, 8'h00};
      endcase
      fcs_pkg::OP_ABORT: r = {1'b1, (s == 4'h2) ? fcs_pkg::CMD_READ : fcs_pkg::CMD_RESET};
      default: case (s)
        // Caller must have programmed every byte to 00h first
        4'h0: r = {1'b1, fcs_pkg::CMD_ERASE};
        4'h1: r = {1'b1, fcs_pkg::CMD_ERASE};
        4'h2: r = {1'b1, fcs_pkg::CMD_EVERIFY};
        4'h4: r = {1'b1, fcs_pkg::CMD_READ};
        default: r = {1'b0, 8'h00};
      endcase
    endcase
    return r;
  endfunction : step_cmd

  function automatic logic [3:0] last_step(input logic [1:0] o);
    case (o)
      fcs_pkg::OP_READ: last_step = 4'h1;
      fcs_pkg::OP_SIG: last_step = 4'h3;
      fcs_pkg::OP_ABORT: last_step = 4'h2;
      default: last_step = 4'h4;
    endcase
  endfunction : last_step

  always_comb begin
    logic [8:0] sc;
    logic [31:0] erase_len;
    sc = step_cmd(op, step);
    erase_len = ERASE_CYCLES;
    next_state = state;
    next_pins = pins;
    next_step = step;
    next_op = op;
    next_vaddr = vaddr;
    next_cnt = cnt;
    next_tries = tries;
    next_rdata = rdata;
    next_maker = maker;
    next_dev = dev;
    next_fail = fail;
    case (state)
      S_IDLE: begin
        next_pins.ce_n = 1'b1;
        next_pins.we_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        if (START) begin
          next_op = OP;
          next_step = 4'h0;
          next_vaddr = 17'h00000;
          next_tries = 16'h0000;
          next_fail = 1'b0;
          next_state = S_GAP;
        end
      end
      S_GAP: begin
        // Present address, data and select together, before the strobe falls
        next_pins.oe_n = 1'b1;
        next_pins.ce_n = 1'b0;
        next_cnt = 32'd0;
        if (sc[8]) begin
          next_pins.addr = (op == fcs_pkg::OP_ERASE && step == 4'h2) ? vaddr : 17'h00000;
          next_pins.dq_out = sc[7:0];
          next_pins.dq_oe = 1'b1;
          next_state = S_WLOW;
        end else begin
          next_pins.dq_oe = 1'b0;
          if (op == fcs_pkg::OP_SIG) begin
            next_pins.addr = (step == 4'h1) ? fcs_pkg::SIG_MAKER_ADDR : fcs_pkg::SIG_DEVICE_ADDR;
          end else if (op == fcs_pkg::OP_READ) begin
            next_pins.addr = ADDR;
          end
          // Verify read keeps the latched address on the pins anyway
          next_state = S_RWAIT;
        end
      end
      S_WLOW: begin
        next_pins.we_n = 1'b0;
        next_cnt = cnt + 32'd1;
        if (cnt >= 32'(fcs_pkg::WRITE_PULSE_CYC)) begin
          next_cnt = 32'd0;
          next_state = S_WHIGH;
        end
      end
      S_WHIGH: begin
        // Device latches data at this rising edge
        next_pins.we_n = 1'b1;
        next_cnt = cnt + 32'd1;
        if (cnt >= 32'(fcs_pkg::WRITE_HIGH_CYC)) begin
          next_cnt = 32'd0;
          next_pins.dq_oe = 1'b0;
          next_pins.ce_n = 1'b1;
          next_state = (op == fcs_pkg::OP_ERASE && step == 4'h1) ? S_ERWAIT : S_NEXT;
        end
      end
      S_ERWAIT: begin
        next_cnt = cnt + 32'd1;
        if (cnt >= erase_len) begin
          next_state = S_NEXT;
        end
      end
      S_RWAIT: begin
        // Output enable stays off through the write-to-read gap, then the access time runs
        next_pins.oe_n = (cnt < 32'(fcs_pkg::WRITE_TO_READ_CYC));
        next_cnt = cnt + 32'd1;
        if (cnt >= 32'(fcs_pkg::WRITE_TO_READ_CYC + fcs_pkg::READ_ACCESS_CYC)) begin
          next_state = S_RDO;
        end
      end
      S_RDO: begin
        next_pins.oe_n = 1'b1;
        next_pins.ce_n = 1'b1;
        next_rdata = dq_s2;
        if (op == fcs_pkg::OP_SIG && step == 4'h1) begin
          next_maker = dq_s2;
        end
        if (op == fcs_pkg::OP_SIG && step == 4'h2) begin
          next_dev = dq_s2;
        end
        next_state = S_NEXT;
        if (op == fcs_pkg::OP_ERASE) begin
          if (dq_s2 != fcs_pkg::ERASED_BYTE) begin
            next_tries = tries + 16'h0001;
            next_step = 4'h0;
            // Restart erase; vaddr kept so verify resumes here
            next_state = (tries >= 16'(MAX_ERASE_TRIES - 1)) ? S_DONE : S_GAP;
            next_fail = (tries >= 16'(MAX_ERASE_TRIES - 1));
          end else if (vaddr != LAST_ADDR) begin
            next_vaddr = vaddr + 17'h00001;
            next_step = 4'h2;
            next_state = S_GAP;
          end
        end
      end
      S_NEXT: begin
        if (step == last_step(op)) begin
          next_state = S_DONE;
        end else begin
          next_step = step + 4'h1;
          next_state = S_GAP;
        end
      end
      S_DONE: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= S_IDLE;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 17'h00000, dq_out: 8'h00, dq_oe: 1'b0};
      step <= 4'h0;
      op <= 2'h0;
      vaddr <= 17'h00000;
      cnt <= 32'd0;
      tries <= 16'h0000;
      rdata <= 8'h00;
      maker <= 8'h00;
      dev <= 8'h00;
      fail <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      step <= next_step;
      op <= next_op;
      vaddr <= next_vaddr;
      cnt <= next_cnt;
      tries <= next_tries;
      rdata <= next_rdata;
      maker <= next_maker;
      dev <= next_dev;
      fail <= next_fail;
    end
  end

  assign BUSY = (state != S_IDLE);
  assign DONE = (state == S_DONE);
  assign FAIL = fail;
  assign RDATA = rdata;
  assign SIG_MAKER = maker;
  assign SIG_DEVICE = dev;
  assign F_ADDR = pins.addr;
  assign F_CE_N = pins.ce_n;
  assign F_WE_N = pins.we_n;
  assign F_OE_N = pins.oe_n;
  assign F_DQ_O = pins.dq_out;
  assign F_DQ_OE = pins.dq_oe;
endmodule : fcs_host

// File: sim/fcs_flash_mdl.sv
// Behavioural flash device answering the host pins
`timescale 1ns/1ps
module fcs_flash_mdl #(
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary maker code
  parameter logic [7:0] DEVICE = 8'hC3 // Arbitrary device code
) (
  input wire logic [16:0] F_ADDR, // Address
  input wire logic F_CE_N, // Chip enable
  input wire logic F_WE_N, // Write strobe
  input wire logic F_OE_N, // Output enable
  input wire logic [7:0] F_DQ_I, // Wire level
  input wire logic HOLD_BAD, // Erase never clears the top byte
  output logic [7:0] MDL_Q // Device drive
);
  logic [7:0] mem [0:3];
  logic [7:0] cmd = fcs_pkg::CMD_READ;
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  logic [16:0] a_lat;
  logic [16:0] v_addr;
  logic erasing = 1'b0;
  int erases = 0;
  initial foreach (mem[i]) mem[i] = fcs_pkg::ZERO_BYTE;
  always @(negedge F_WE_N) if (!F_CE_N) a_lat = F_ADDR;
  always @(posedge F_WE_N) if (!F_CE_N) begin
    if (F_DQ_I == fcs_pkg::CMD_ERASE && cmd == fcs_pkg::CMD_ERASE) begin
      erasing = 1'b1;
      // First pass leaves the upper bytes programmed so the host must retry
      // HOLD_BAD keeps the top byte programmed so the retry limit is reached
      foreach (mem[i]) mem[i] = ((erases == 0 && i >= 2) || (HOLD_BAD && i == 3)) ? 8'h00 : fcs_pkg::ERASED_BYTE;
      erases++;
      cmd = 8'h21;
    end else begin
      if (F_DQ_I == fcs_pkg::CMD_EVERIFY) begin
        erasing = 1'b0;
        v_addr = a_lat;
      end
      if (F_DQ_I == fcs_pkg::CMD_RESET && cmd == fcs_pkg::CMD_RESET) erasing = 1'b0;
      cmd = F_DQ_I;
    end
  end
  always_comb begin
    case (cmd)
      fcs_pkg::CMD_SIG: rd = (F_ADDR == fcs_pkg::SIG_DEVICE_ADDR) ? DEVICE : MAKER;
      fcs_pkg::CMD_EVERIFY: rd = mem[v_addr[1:0]];
      default: rd = mem[F_ADDR[1:0]];
    endcase
  end
  always @(rd, F_CE_N, F_OE_N) if (!F_CE_N && !F_OE_N) last = rd;
  // Released bus shows the inverse so a stale byte never passes for fresh data
  assign MDL_Q = (!F_CE_N && !F_OE_N) ? rd : ~last;
endmodule : fcs_flash_mdl

// File: sim/fcs_host_chk.sv
// Pin and handshake assertions for the flash command host
`timescale 1ns/1ps
module fcs_host_chk (
  input wire logic SYS_CLK, // Clock
  input wire logic RSTN, // Reset
  input wire logic START, // Start
  input wire logic BUSY, // Busy
  input wire logic DONE, // Done
  input wire logic [16:0] F_ADDR, // Address
  input wire logic F_CE_N, // Chip enable
  input wire logic F_WE_N, // Write strobe
  input wire logic F_OE_N, // Output enable
  input wire logic [7:0] F_DQ_O, // Data out
  input wire logic F_DQ_OE // Data drive
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence wlow_s; !F_WE_N [*2] ##1 F_WE_N; endsequence
  sequence wmid_s; !F_WE_N && !$fell(F_WE_N); endsequence
  take_op_a: assert property (START && !BUSY |=> BUSY) else $error("start not taken");
  write_sel_a: assert property (!F_WE_N |-> !F_CE_N && F_OE_N && F_DQ_OE) else $error("bad write");
  write_pulse_a: assert property ($fell(F_WE_N) |-> wlow_s) else $error("bad strobe width");
  write_hold_a: assert property (wmid_s |-> $stable(F_ADDR) && $stable(F_DQ_O)) else $error("moved");
  read_sel_a: assert property (!F_OE_N |-> !F_CE_N && F_WE_N && !F_DQ_OE) else $error("bad read");
  read_hold_a: assert property (!F_OE_N && !$fell(F_OE_N) |-> $stable(F_ADDR)) else $error("moved");
  done_pulse_a: assert property (DONE |=> !DONE) else $error("done too long");
  idle_pins_a: assert property (!BUSY |-> F_CE_N && F_WE_N && F_OE_N && !F_DQ_OE) else $error("idle pins");
endmodule : fcs_host_chk
bind fcs_host fcs_host_chk i_chk (.*);

// File: sim/testbench.sv
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [1:0] op;
    logic [16:0] addr;
    logic [7:0] rdata;
  } fcs_row_t;
  localparam logic [7:0] MAKER_ID = 8'h5A; // Arbitrary
  localparam logic [7:0] DEVICE_ID = 8'hC3; // Arbitrary
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic START = 1'b0;
  logic [1:0] OP = 2'h0;
  logic [16:0] ADDR = 17'h00000;
  logic HOLD_BAD = 1'b0;
  logic BUSY, DONE, FAIL, F_CE_N, F_WE_N, F_OE_N, F_DQ_OE;
  logic [7:0] RDATA, SIG_MAKER, SIG_DEVICE, F_DQ_O, MDL_Q;
  logic [16:0] F_ADDR;
  wire logic [7:0] F_DQ_I;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  fcs_row_t rows [6];
  assign F_DQ_I = F_DQ_OE ? F_DQ_O : MDL_Q;
  fcs_host #(.ERASE_CYCLES(20), .MAX_ERASE_TRIES(4), .LAST_ADDR(17'h00003)) i_dut (.*);
  fcs_flash_mdl #(.MAKER(MAKER_ID), .DEVICE(DEVICE_ID)) i_mdl (.*);
  initial forever #50 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic run_op(input logic [1:0] op, input logic [16:0] addr);
    int n;
    @(negedge SYS_CLK);
    START = 1'b1;
    OP = op;
    ADDR = addr;
    @(negedge SYS_CLK);
    START = 1'b0;
    n = 0;
    while (DONE !== 1'b1 && n < 5000) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk("DONE", 8'h01, {7'h00, DONE});
    @(negedge SYS_CLK);
  endtask : run_op
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    rows = '{'{fcs_pkg::OP_READ, 17'h00001, 8'h00}, '{fcs_pkg::OP_SIG, 17'h00000, 8'h00},
      '{fcs_pkg::OP_READ, 17'h00000, 8'h00}, '{fcs_pkg::OP_ERASE, 17'h00000, 8'h00},
      '{fcs_pkg::OP_ABORT, 17'h00000, 8'h00}, '{fcs_pkg::OP_READ, 17'h00003, 8'hFF}};
    repeat (20) @(negedge SYS_CLK);
    RSTN = 1'b1;
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].addr);
      if (rows[i].op == fcs_pkg::OP_READ) chk("RDATA", rows[i].rdata, RDATA);
      if (rows[i].op == fcs_pkg::OP_SIG) begin
        chk("SIG_MAKER", MAKER_ID, SIG_MAKER);
        chk("SIG_DEVICE", DEVICE_ID, SIG_DEVICE);
      end
      if (rows[i].op == fcs_pkg::OP_ERASE) begin
        chk("FAIL", 8'h00, {7'h00, FAIL});
        chk("erase_runs", 8'h02, 8'(i_mdl.erases));
      end
      chk("erasing", 8'h00, {7'h00, i_mdl.erasing});
    end
    // Stuck byte: host gives up after the retry limit
    HOLD_BAD = 1'b1;
    run_op(fcs_pkg::OP_ERASE, 17'h00000);
    chk("FAIL", 8'h01, {7'h00, FAIL});
    chk("erase_runs", 8'h06, 8'(i_mdl.erases));
    HOLD_BAD = 1'b0;
    // Reset lands while the device erases
    run_op(fcs_pkg::OP_ERASE, 17'h00000);
    @(negedge SYS_CLK);
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    repeat (25) @(negedge SYS_CLK);
    RSTN = 1'b0;
    @(negedge SYS_CLK);
    chk("pins_in_reset", 8'h38, {2'h0, F_CE_N, F_WE_N, F_OE_N, F_DQ_OE, BUSY, DONE});
    RSTN = 1'b1;
    fork
      run_op(fcs_pkg::OP_READ, 17'h00002);
      begin
        repeat (5) @(negedge SYS_CLK);
        START = 1'b1;
        OP = fcs_pkg::OP_ERASE;
        @(negedge SYS_CLK);
        START = 1'b0;
      end
    join
    chk("RDATA", 8'hFF, RDATA);
    chk("erase_runs", 8'h08, 8'(i_mdl.erases));
    test_done();
  end
endmodule : testbench
